// >>> design/afp_pkg.sv
package afp_pkg;
	// ****************************************
	// widths and positions
	// ****************************************
	localparam int          DATA_W      = 8;
	localparam int          PC_W        = 12;
	localparam int          PCL_W       = 8;
	localparam int          PCH_W       = 4;
	localparam int          BUS_W       = 32;
	localparam int          IDX_LSB     = 2;
	localparam int          IDX_W       = 8;
	localparam int          FLG_Z_BIT   = 0;
	localparam int          FLG_DC_BIT  = 1;
	localparam int          FLG_C_BIT   = 2;
	localparam int          FLG_RL_BIT  = 6;
	localparam int          FLG_RH_BIT  = 7;

	// ****************************************
	// register indices, byte address = index * 4
	// ****************************************
	localparam logic [7:0]  IDX_FLAGS   = 8'h86;
	localparam logic [7:0]  IDX_PCL     = 8'hCE;
	localparam logic [7:0]  IDX_PCH     = 8'hCF;
	localparam int          ADDR_HI_LSB = IDX_LSB + IDX_W;

	// ****************************************
	// values
	// ****************************************
	localparam logic [11:0] PC_RESET    = 12'h000;
	localparam logic [11:0] PC_STEP     = 12'h001;
	localparam logic [11:0] PC_SKIP     = 12'h002;
	localparam logic [3:0]  PCH_STEP    = 4'h1;
	localparam logic [7:0]  BYTE_ONE    = 8'h01;
	localparam logic [7:0]  BYTE_ZERO   = 8'h00;
	localparam logic [1:0]  CAUSE_WDT   = 2'h0;
	localparam logic [1:0]  CAUSE_RSVD  = 2'h1;
	localparam logic [1:0]  CAUSE_LVD   = 2'h2;
	localparam logic [1:0]  CAUSE_PIN   = 2'h3;
	localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

	// ****************************************
	// operations from instruction decode
	// ****************************************
	typedef enum logic [3:0] {
		OP_STEP  = 4'h0,
		OP_ALU   = 4'h1,
		OP_JUMP  = 4'h2,
		OP_CMPS  = 4'h3,
		OP_INC_TO_ACC_SKIP  = 4'h4,
		OP_DEC_TO_ACC_SKIP  = 4'h5,
		OP_BITS  = 4'h6,
		OP_XCH   = 4'h7,
		OP_PCADD = 4'h8,
		OP_PCSUB = 4'h9,
		OP_PCMOV = 4'hA,
		OP_PUSH  = 4'hB,
		OP_POP   = 4'hC,
		OP_IRQ   = 4'hD
	} afp_op_t;

	typedef enum logic [2:0] {
		CL_ADD   = 3'h0,
		CL_SUB   = 3'h1,
		CL_CMP   = 3'h2,
		CL_RRC   = 3'h3,
		CL_RLC   = 3'h4,
		CL_LOGIC = 3'h5
	} afp_class_t;

	typedef struct packed {
		logic [11:0] pc;
		logic [7:0]  acc;
		logic        c;
		logic        dc;
		logic        z;
		logic [1:0]  cause;
		logic        caught;
		logic [31:0] rdata;
		logic        wr_pend;
		logic [7:0]  wr_idx;
		logic [7:0]  mem_wdata;
		logic        mem_we;
		logic        skip;
	} afp_state_t;
endpackage

// >>> design/afp_flag_eval.sv
`timescale 1ns/1ps
`default_nettype none
module afp_flag_eval import afp_pkg::*; (
	input  wire afp_class_t  op_class,
	input  wire logic [7:0]  a,
	input  wire logic [7:0]  b,
	input  wire logic        cin,
	input  wire logic        use_cin,
	output logic      [7:0]  res,
	output logic             c,
	output logic             dc,
	output logic             upd_c,
	output logic             upd_dc,
	output logic             z
);
	logic [8:0] wide;
	logic [4:0] nib;
	logic       ci;

	always_comb begin
		ci     = use_cin & cin;
		wide   = '0;
		nib    = '0;
		res    = b;
		c      = 1'b0;
		dc     = 1'b0;
		upd_c  = 1'b1;
		upd_dc = 1'b1;
		unique case (op_class)
			CL_ADD: begin
				wide = {1'b0, a} + {1'b0, b} + {8'h00, ci};
				nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
			end
			CL_SUB, CL_CMP: begin
				// carry set means no borrow
				wide = {1'b0, a} + {1'b0, ~b} + {8'h00, ~(use_cin & ~cin)};
				nib  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]}
					+ {4'h0, ~(use_cin & ~cin)};
			end
			default: ;
		endcase
		unique case (op_class)
			CL_ADD, CL_SUB, CL_CMP: begin
				res = wide[7:0];
				c   = wide[8];
				dc  = nib[4];
			end
			CL_RRC: begin
				res    = {ci, b[7:1]};
				c      = b[0];
				upd_dc = 1'b0;
			end
			CL_RLC: begin
				res    = {b[6:0], ci};
				c      = b[7];
				upd_dc = 1'b0;
			end
			default: begin
				upd_c  = 1'b0;
				upd_dc = 1'b0;
			end
		endcase
		z = (res == BYTE_ZERO);
	end
endmodule
`default_nettype wire

// >>> design/afp_core.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - 8-bit accumulator; add and subtract operations update Z, C, DC
// - accumulator is not a memory location
// - interrupt entry saves neither accumulator nor flags
// - push/pop covers flags, not accumulator
// - exchange with memory leaves flags unchanged
// - flag bits 7:6 hold last reset cause
// - carry at bit 2 per arithmetic rule
// - nibble carry at bit 1 per nibble rule
// - zero flag at bit 0 tracks result
// - 12-bit program counter gives fetch address
// - counter advances by one per instruction
// - jump or call loads full destination
// - true skip condition advances counter by two
// - compare skips when accumulator equals operand, or operand plus one with op_use_carry set and carry clear
// - increment skips on wrap to zero
// - decrement skips on one to zero
// - bit test skips when polarity matches
// - low byte add overflow bumps high byte
// - low byte subtract borrow keeps high byte
// - low byte move stays in current page
module afp_core import afp_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [1:0]  reset_cause_in,
	input  wire logic        op_valid,
	input  wire afp_op_t     op_code,
	input  wire afp_class_t  op_class,
	input  wire logic        op_dest_acc,
	input  wire logic        op_use_carry,
	input  wire logic [7:0]  op_operand,
	input  wire logic [2:0]  op_bit_sel,
	input  wire logic        op_bit_pol,
	input  wire logic [11:0] op_target,
	output logic      [11:0] fetch_addr,
	output logic      [7:0]  accumulator_reg,
	output logic      [7:0]  program_status_flags,
	output logic      [7:0]  mem_wdata,
	output logic             mem_we,
	output logic             skip_taken
);
	// ****************************************
	// state and helpers
	// ****************************************
	afp_state_t state;
	afp_state_t next_state;
	logic       addr_ph;
	logic [7:0] addr_idx;
	logic       on_pc;
	afp_class_t ev_class;
	logic [7:0] ev_a;
	logic [7:0] ev_b;
	logic [7:0] ev_res;
	logic       ev_c;
	logic       ev_dc;
	logic       ev_uc;
	logic       ev_udc;
	logic       ev_z;
	logic [7:0] inc_val;
	logic [7:0] dec_val;
	logic       bit_hit;

	function automatic logic [7:0] flags_byte(input afp_state_t st);
		logic [7:0] f;
		f              = '0;
		f[FLG_Z_BIT]   = st.z;
		f[FLG_DC_BIT]  = st.dc;
		f[FLG_C_BIT]   = st.c;
		f[FLG_RL_BIT]  = st.cause[0];
		f[FLG_RH_BIT]  = st.cause[1];
		return f;
	endfunction

	function automatic logic reg_hit(input logic [7:0] idx);
		// accumulator has no index here
		return (idx == IDX_FLAGS) || (idx == IDX_PCL)
			|| (idx == IDX_PCH);
	endfunction

	function automatic logic [31:0] reg_read(input afp_state_t st,
		input logic [7:0] idx);
		logic [31:0] v;
		v = '0;
		if (reg_hit(idx)) begin
			if (idx == IDX_FLAGS) begin
				v[7:0] = flags_byte(st);
			end else if (idx == IDX_PCL) begin
				v[7:0] = st.pc[PCL_W-1:0];
			end else begin
				v[3:0] = st.pc[PC_W-1:PCL_W];
			end
		end
		return v;
	endfunction

	// ****************************************
	// bus address phase
	// ****************************************
	assign addr_ph  = hsel && hready && (htrans == HTRANS_NSEQ)
		&& (haddr[31:ADDR_HI_LSB] == '0);
	assign addr_idx = haddr[ADDR_HI_LSB-1:IDX_LSB];

	// ****************************************
	// flag evaluation
	// ****************************************
	assign on_pc    = op_valid
		&& ((op_code == OP_PCADD) || (op_code == OP_PCSUB));
	assign ev_a     = on_pc ? state.pc[PCL_W-1:0] : state.acc;
	assign ev_b     = on_pc ? state.acc : op_operand;
	assign inc_val  = op_operand + BYTE_ONE;
	assign dec_val  = op_operand - BYTE_ONE;
	assign bit_hit  = (op_operand[op_bit_sel] == op_bit_pol);

	always_comb begin
		ev_class = op_class;
		if (op_code == OP_PCADD) begin
			ev_class = CL_ADD;
		end else if (op_code == OP_PCSUB) begin
			ev_class = CL_SUB;
		end else if (op_code == OP_CMPS) begin
			ev_class = CL_CMP;
		end
	end

	afp_flag_eval u_eval (
		.op_class (ev_class),
		.a        (ev_a),
		.b        (ev_b),
		.cin      (state.c),
		.use_cin  (op_use_carry),
		.res      (ev_res),
		.c        (ev_c),
		.dc       (ev_dc),
		.upd_c    (ev_uc),
		.upd_dc   (ev_udc),
		.z        (ev_z)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_state        = state;
		next_state.mem_we = 1'b0;
		next_state.skip   = 1'b0;
		if (!state.caught) begin
			next_state.cause  = reset_cause_in;
			next_state.caught = 1'b1;
		end
		if (op_valid) begin
			next_state.pc = state.pc + PC_STEP;
			unique case (op_code)
				OP_STEP: ;
				OP_ALU: begin
					if (ev_uc) next_state.c = ev_c;
					if (ev_udc) next_state.dc = ev_dc;
					next_state.z = ev_z;
					if (op_class != CL_CMP) begin
						if (op_dest_acc) begin
							next_state.acc = ev_res;
						end else begin
							next_state.mem_wdata = ev_res;
							next_state.mem_we    = 1'b1;
						end
					end
				end
				OP_JUMP, OP_IRQ: begin
					// no hardware save of acc or flags
					next_state.pc = op_target;
				end
				OP_CMPS: begin
					next_state.c = ev_c;
					next_state.z = ev_z;
					if (ev_z) begin
						next_state.pc   = state.pc + PC_SKIP;
						next_state.skip = 1'b1;
					end
				end
				OP_INC_TO_ACC_SKIP, OP_DEC_TO_ACC_SKIP: begin
					if (op_code == OP_INC_TO_ACC_SKIP) begin
						next_state.mem_wdata = inc_val;
					end else begin
						next_state.mem_wdata = dec_val;
					end
					if (op_dest_acc) begin
						next_state.acc = next_state.mem_wdata;
					end else begin
						next_state.mem_we = 1'b1;
					end
					if ((op_code == OP_INC_TO_ACC_SKIP && inc_val == BYTE_ZERO)
						|| (op_code == OP_DEC_TO_ACC_SKIP && dec_val == BYTE_ZERO)) begin
						next_state.pc   = state.pc + PC_SKIP;
						next_state.skip = 1'b1;
					end
				end
				OP_BITS: begin
					if (bit_hit) begin
						next_state.pc   = state.pc + PC_SKIP;
						next_state.skip = 1'b1;
					end
				end
				OP_XCH: begin
					next_state.acc       = op_operand;
					next_state.mem_wdata = state.acc;
					next_state.mem_we    = 1'b1;
				end
				OP_PCADD, OP_PCSUB: begin
					next_state.c = ev_c;
					next_state.dc = ev_dc;
					next_state.z = ev_z;
					next_state.pc[PCL_W-1:0] = ev_res;
					if (op_code == OP_PCADD && ev_c) begin
						next_state.pc[PC_W-1:PCL_W] =
							state.pc[PC_W-1:PCL_W] + PCH_STEP;
					end else begin
						next_state.pc[PC_W-1:PCL_W] =
							state.pc[PC_W-1:PCL_W];
					end
				end
				OP_PCMOV: begin
					next_state.pc = {state.pc[PC_W-1:PCL_W], op_operand};
				end
				OP_PUSH: begin
					// flags go out, accumulator stays software's job
					next_state.mem_wdata = flags_byte(state);
					next_state.mem_we    = 1'b1;
				end
				OP_POP: begin
					next_state.z     = op_operand[FLG_Z_BIT];
					next_state.dc    = op_operand[FLG_DC_BIT];
					next_state.c     = op_operand[FLG_C_BIT];
					next_state.cause = {op_operand[FLG_RH_BIT],
						op_operand[FLG_RL_BIT]};
				end
				default: ;
			endcase
		end
		// bus data phase write, applied last
		if (state.wr_pend) begin
			if (state.wr_idx == IDX_FLAGS) begin
				next_state.z     = hwdata[FLG_Z_BIT];
				next_state.dc    = hwdata[FLG_DC_BIT];
				next_state.c     = hwdata[FLG_C_BIT];
				next_state.cause = {hwdata[FLG_RH_BIT], hwdata[FLG_RL_BIT]};
			end else if (state.wr_idx == IDX_PCL) begin
				next_state.pc[PCL_W-1:0] = hwdata[PCL_W-1:0];
			end else if (state.wr_idx == IDX_PCH) begin
				next_state.pc[PC_W-1:PCL_W] = hwdata[PCH_W-1:0];
			end
		end
		next_state.wr_pend = addr_ph && hwrite && reg_hit(addr_idx);
		next_state.wr_idx  = addr_idx;
		if (addr_ph && !hwrite) begin
			next_state.rdata = reg_read(next_state, addr_idx);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state        <= '0;
			state.pc     <= PC_RESET;
			state.cause  <= CAUSE_PIN;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign hrdata               = state.rdata;
	assign hreadyout            = 1'b1;
	assign hresp                = 1'b0;
	assign fetch_addr           = state.pc;
	assign accumulator_reg      = state.acc;
	assign program_status_flags = flags_byte(state);
	assign mem_wdata            = state.mem_wdata;
	assign mem_we               = state.mem_we;
	assign skip_taken           = state.skip;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	step_pc_a: assert property ((op_valid && op_code == OP_STEP
		&& !state.wr_pend) |=> (state.pc == $past(state.pc) + PC_STEP))
		else $error("program counter did not advance by one");

	jump_pc_a: assert property ((op_valid && op_code == OP_JUMP
		&& !state.wr_pend) |=> (state.pc == $past(op_target)))
		else $error("jump target not loaded");

	bit_skip_a: assert property ((op_valid && op_code == OP_BITS
		&& bit_hit && !state.wr_pend)
		|=> (skip_taken && state.pc == $past(state.pc) + PC_SKIP))
		else $error("bit test skip not taken");

	cmp_skip_a: assert property ((op_valid && op_code == OP_CMPS
		&& !state.wr_pend) |=> (skip_taken
		== ($past(state.acc) == $past(op_operand))))
		else $error("compare skip wrong");

	inc_skip_a: assert property ((op_valid && op_code == OP_INC_TO_ACC_SKIP
		&& op_operand == 8'hFF && !state.wr_pend) |=> skip_taken)
		else $error("increment wrap skip missing");

	dec_skip_a: assert property ((op_valid && op_code == OP_DEC_TO_ACC_SKIP
		&& !state.wr_pend) |=> (skip_taken == ($past(op_operand) == 8'h01)))
		else $error("decrement skip wrong");

	pch_carry_a: assert property ((op_valid && op_code == OP_PCADD
		&& ev_c && !state.wr_pend) |=> (state.pc[PC_W-1:PCL_W]
		== $past(state.pc[PC_W-1:PCL_W]) + PCH_STEP))
		else $error("high byte not bumped on overflow");

	pch_borrow_a: assert property ((op_valid && op_code == OP_PCSUB
		&& !state.wr_pend) |=> $stable(state.pc[PC_W-1:PCL_W]))
		else $error("high byte changed on subtract");

	pcl_move_a: assert property ((op_valid && op_code == OP_PCMOV
		&& !state.wr_pend) |=> (state.pc == {$past(state.pc[PC_W-1:PCL_W]),
		$past(op_operand)}))
		else $error("low byte move left the page");

	xch_flags_a: assert property ((op_valid && op_code == OP_XCH
		&& !state.wr_pend) |=> ($stable(program_status_flags)
		&& accumulator_reg == $past(op_operand) && mem_we))
		else $error("exchange disturbed flags or data");

	irq_keep_a: assert property ((op_valid && op_code == OP_IRQ
		&& !state.wr_pend) |=> ($stable(accumulator_reg)
		&& $stable(program_status_flags)))
		else $error("interrupt entry touched acc or flags");

	alu_zero_a: assert property ((op_valid && op_code == OP_ALU
		&& !state.wr_pend) |=> (state.z == ($past(ev_res) == BYTE_ZERO)))
		else $error("zero flag does not match result");
endmodule
`default_nettype wire

// >>> tb/afp_decode_model.sv
`timescale 1ns/1ps
`default_nettype none
module afp_decode_model import afp_pkg::*; (
	input  wire logic        hclk,
	output var logic         op_valid,
	output var afp_op_t      op_code,
	output var afp_class_t   op_class,
	output var logic         op_dest_acc,
	output var logic         op_use_carry,
	output var logic [7:0]   op_operand,
	output var logic [2:0]   op_bit_sel,
	output var logic         op_bit_pol,
	output var logic [11:0]  op_target
);
	initial begin
		op_valid = 1'b0;
		op_code = OP_STEP;
		op_class = CL_ADD;
		op_dest_acc = 1'b0;
		op_use_carry = 1'b0;
		op_operand = 8'h00;
		op_bit_sel = 3'h0;
		op_bit_pol = 1'b0;
		op_target = 12'h000;
	end

	// call right after a rising edge; the op is taken at the next one
	task automatic issue(input afp_op_t c, input afp_class_t k,
		input logic d, input logic u, input logic [11:0] a);
		op_valid <= 1'b1;
		op_code <= c;
		op_class <= k;
		op_dest_acc <= d;
		op_use_carry <= u;
		op_operand <= a[7:0];
		op_bit_sel <= a[10:8];
		op_bit_pol <= a[11];
		op_target <= a;
		@(posedge hclk);
	endtask

	// released operand and target no longer show the last value
	task automatic idle();
		op_valid <= 1'b0;
		op_operand <= ~op_operand;
		op_target <= ~op_target;
	endtask
endmodule
`default_nettype wire

// >>> tb/acc_flags_pc_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module acc_flags_pc_sequencer_tb_top import afp_pkg::*;;
	typedef struct packed {
		afp_op_t     op;
		afp_class_t  cl;
		logic        d;
		logic [11:0] a;
		logic [11:0] pc;
		logic [7:0]  acc;
		logic [2:0]  flg;
		logic [1:0]  sw;
		logic [7:0]  wd;
	} afp_row_t;

	logic        hclk, hresetn, hsel, hwrite, op_valid, op_dest_acc;
	logic        op_use_carry, op_bit_pol, hreadyout, hresp, mem_we;
	logic        skip_taken;
	wire logic   hready;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans, reset_cause_in;
	logic [2:0]  hsize, op_bit_sel;
	logic [7:0]  op_operand, accumulator_reg, program_status_flags, mem_wdata;
	logic [11:0] op_target, fetch_addr;
	afp_op_t     op_code;
	afp_class_t  op_class;
	afp_row_t    rows[$];
	int          fails, n_tests;

	assign hready = hreadyout;

	afp_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.reset_cause_in(reset_cause_in), .op_valid(op_valid),
		.op_code(op_code), .op_class(op_class), .op_dest_acc(op_dest_acc),
		.op_use_carry(op_use_carry), .op_operand(op_operand),
		.op_bit_sel(op_bit_sel), .op_bit_pol(op_bit_pol),
		.op_target(op_target), .fetch_addr(fetch_addr),
		.accumulator_reg(accumulator_reg),
		.program_status_flags(program_status_flags),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .skip_taken(skip_taken));

	afp_decode_model model_u (.hclk(hclk), .op_valid(op_valid),
		.op_code(op_code), .op_class(op_class), .op_dest_acc(op_dest_acc),
		.op_use_carry(op_use_carry), .op_operand(op_operand),
		.op_bit_sel(op_bit_sel), .op_bit_pol(op_bit_pol),
		.op_target(op_target));

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		if (fails == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// one single word transfer; call right after a rising edge
	task automatic ahb(input logic w, input logic [7:0] idx,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= HTRANS_NSEQ;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'b00};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic row(input afp_op_t o, input afp_class_t k, input logic d,
		input logic [11:0] a, input logic [11:0] p, input logic [7:0] ac,
		input logic [2:0] f, input logic [1:0] sw, input logic [7:0] wd);
		rows.push_back('{o, k, d, a, p, ac, f, sw, wd});
	endtask

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	initial begin
		repeat (3000) @(posedge hclk);
		fails++;
		final_report();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		reset_cause_in = CAUSE_LVD;
		fails = 0;
		n_tests = 0;
		row(OP_STEP, CL_ADD, 1'b1, 12'h000, 12'h001, 8'h00, 3'h0, 2'h0, 8'h00);
		row(OP_ALU, CL_ADD, 1'b1, 12'h08F, 12'h002, 8'h8F, 3'h0, 2'h0, 8'h00);
		row(OP_ALU, CL_ADD, 1'b1, 12'h081, 12'h003, 8'h10, 3'h6, 2'h0, 8'h00);
		row(OP_ALU, CL_SUB, 1'b1, 12'h010, 12'h004, 8'h00, 3'h7, 2'h0, 8'h00);
		row(OP_ALU, CL_SUB, 1'b1, 12'h001, 12'h005, 8'hFF, 3'h0, 2'h0, 8'h00);
		row(OP_CMPS, CL_CMP, 1'b1, 12'h0FF, 12'h007, 8'hFF, 3'h5, 2'h2, 8'h00);
		row(OP_CMPS, CL_CMP, 1'b1, 12'h000, 12'h008, 8'hFF, 3'h4, 2'h0, 8'h00);
		row(OP_INC_TO_ACC_SKIP, CL_ADD, 1'b1, 12'h0FF, 12'h00A, 8'h00, 3'h4, 2'h2, 8'h00);
		row(OP_INC_TO_ACC_SKIP, CL_ADD, 1'b1, 12'h0FE, 12'h00B, 8'hFF, 3'h4, 2'h0, 8'h00);
		row(OP_DEC_TO_ACC_SKIP, CL_ADD, 1'b1, 12'h001, 12'h00D, 8'h00, 3'h4, 2'h2, 8'h00);
		row(OP_DEC_TO_ACC_SKIP, CL_ADD, 1'b1, 12'h000, 12'h00E, 8'hFF, 3'h4, 2'h0, 8'h00);
		row(OP_BITS, CL_ADD, 1'b1, 12'hD20, 12'h010, 8'hFF, 3'h4, 2'h2, 8'h00);
		row(OP_BITS, CL_ADD, 1'b1, 12'h520, 12'h011, 8'hFF, 3'h4, 2'h0, 8'h00);
		row(OP_BITS, CL_ADD, 1'b1, 12'h000, 12'h013, 8'hFF, 3'h4, 2'h2, 8'h00);
		row(OP_XCH, CL_ADD, 1'b1, 12'h03C, 12'h014, 8'h3C, 3'h4, 2'h1, 8'hFF);
		row(OP_JUMP, CL_ADD, 1'b1, 12'h3F0, 12'h3F0, 8'h3C, 3'h4, 2'h0, 8'h00);
		row(OP_PCADD, CL_ADD, 1'b1, 12'h000, 12'h42C, 8'h3C, 3'h4, 2'h0, 8'h00);
		row(OP_PCSUB, CL_SUB, 1'b1, 12'h000, 12'h4F0, 8'h3C, 3'h2, 2'h0, 8'h00);
		row(OP_PCMOV, CL_ADD, 1'b1, 12'h055, 12'h455, 8'h3C, 3'h2, 2'h0, 8'h00);
		row(OP_IRQ, CL_ADD, 1'b1, 12'h008, 12'h008, 8'h3C, 3'h2, 2'h0, 8'h00);
		row(OP_ALU, CL_ADD, 1'b0, 12'h0C4, 12'h009, 8'h3C, 3'h7, 2'h1, 8'h00);
		row(OP_ALU, CL_RLC, 1'b1, 12'h081, 12'h00A, 8'h02, 3'h6, 2'h0, 8'h00);
		row(OP_ALU, CL_RRC, 1'b1, 12'h001, 12'h00B, 8'h00, 3'h7, 2'h0, 8'h00);
		row(OP_ALU, CL_LOGIC, 1'b1, 12'h0BC, 12'h00C, 8'hBC, 3'h6, 2'h0, 8'h00);
		row(OP_PUSH, CL_ADD, 1'b1, 12'h000, 12'h00D, 8'hBC, 3'h6, 2'h1, 8'h86);
		row(OP_POP, CL_ADD, 1'b1, 12'h081, 12'h00E, 8'hBC, 3'h1, 2'h0, 8'h00);
		row(OP_INC_TO_ACC_SKIP, CL_ADD, 1'b0, 12'h0FF, 12'h010, 8'hBC, 3'h1, 2'h3, 8'h00);
		repeat (12) @(posedge hclk);
		chk(32'({fetch_addr, accumulator_reg}), 32'h0);
		hresetn <= 1'b1;
		foreach (rows[i]) begin
			@(posedge hclk);
			model_u.issue(rows[i].op, rows[i].cl, rows[i].d, 1'b0, rows[i].a);
			model_u.idle();
			#1;
			chk(32'(fetch_addr), 32'(rows[i].pc));
			chk(32'(accumulator_reg), 32'(rows[i].acc));
			chk(32'(program_status_flags), 32'({CAUSE_LVD, 3'h0, rows[i].flg}));
			chk(32'({skip_taken, mem_we}), 32'(rows[i].sw));
			if (rows[i].sw[0]) chk(32'(mem_wdata), 32'(rows[i].wd));
		end
		// ****************************************
		// register bus, back-to-back ops, resets
		// ****************************************
		@(posedge hclk);
		ahb(1'b0, IDX_FLAGS, 32'h0, r);
		chk(r, 32'h0000_0081);
		ahb(1'b1, IDX_FLAGS, 32'h0000_0005, r);
		ahb(1'b0, IDX_FLAGS, 32'h0, r);
		chk(r, 32'h0000_0005);
		ahb(1'b1, IDX_PCL, 32'h0000_0080, r);
		#1;
		chk(32'(fetch_addr), 32'h080);
		@(posedge hclk);
		ahb(1'b1, IDX_PCH, 32'h0000_0005, r);
		ahb(1'b0, IDX_PCL, 32'h0, r);
		chk(r, 32'h0000_0080);
		ahb(1'b0, 8'h85, 32'h0, r);
		chk(r, 32'h0);
		chk(32'({hreadyout, hresp}), 32'h2);
		chk(32'(fetch_addr), 32'h580);
		model_u.issue(OP_PCADD, CL_ADD, 1'b1, 1'b1, 12'h000);
		model_u.issue(OP_STEP, CL_ADD, 1'b1, 1'b0, 12'h000);
		model_u.idle();
		#1;
		chk(32'({fetch_addr, program_status_flags}), 32'h63E04);
		for (int c = 0; c < 4; c++) begin
			@(posedge hclk);
			hresetn <= 1'b0;
			reset_cause_in <= c[1:0];
			repeat (2) @(posedge hclk);
			#1;
			chk(32'({fetch_addr, accumulator_reg, program_status_flags}),
				32'h00000C0);
			chk(32'({mem_we, skip_taken}), 32'h0);
			@(posedge hclk);
			hresetn <= 1'b1;
			repeat (2) @(posedge hclk);
			#1;
			chk(32'(program_status_flags), 32'({c[1:0], 6'h00}));
		end
		final_report();
	end
endmodule
`default_nettype wire
